/* hdl/itc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module itc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= rd_ptr + AW'(1);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// Storage has no reset; out_data shows mem[rd_ptr] even while the FIFO is empty
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
		count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : itc_fifo

/* hdl/itc_pkg.sv */
// Package with register map, field positions, reset values and timer B sources
package itc_pkg;
	localparam logic [3:0] REG_PORT_B_DIRECTION = 4'h3;
	localparam logic [3:0] REG_TIMER_A_LOW_BYTE = 4'h4;
	localparam logic [3:0] REG_TIMER_A_HIGH_BYTE = 4'h5;
	localparam logic [3:0] REG_TIMER_B_LOW_BYTE = 4'h6;
	localparam logic [3:0] REG_TIMER_B_HIGH_BYTE = 4'h7;
	localparam logic [3:0] REG_EVENT_COUNT_LOW = 4'h8;
	localparam logic [3:0] REG_EVENT_COUNT_MID = 4'h9;
	localparam logic [3:0] REG_EVENT_COUNT_HIGH = 4'ha;
	localparam logic [3:0] REG_SERIAL_SHIFT_DATA = 4'hc;
	localparam logic [3:0] REG_INTERRUPT_CONTROL = 4'hd;
	localparam logic [3:0] REG_CONTROL_A = 4'he;
	localparam logic [3:0] REG_CONTROL_B = 4'hf;
	// Control register fields
	localparam int CR_START = 0;
	localparam int CR_PORT_OUT = 1;
	localparam int CR_TOGGLE = 2;
	localparam int CR_ONE_SHOT = 3;
	localparam int CR_LOAD = 4;
	localparam int CRA_SOURCE = 5;
	localparam int CRA_SERIAL_DIR = 6;
	localparam int CRB_SOURCE_LO = 5;
	localparam int CRB_ALARM_SEL = 7;
	// Interrupt bit positions
	localparam int IRQ_TA = 0;
	localparam int IRQ_TB = 1;
	localparam int IRQ_ALARM = 2;
	localparam int IRQ_SERIAL = 3;
	localparam int IRQ_FLAG = 4;
	localparam int IRQ_SUMMARY = 7;
	localparam int IRQ_SET_CLEAR = 7;
	// Reset values
	localparam logic [15:0] LATCH_RESET = 16'hffff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [23:0] TOD_RESET = 24'h000000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 8;
	typedef enum logic [1:0]
	{
		TB_SRC_CLOCK = 2'b00,
		TB_SRC_PIN = 2'b01,
		TB_SRC_UNDERFLOW = 2'b10,
		TB_SRC_GATED = 2'b11
	} itc_tb_source_t;
endpackage : itc_pkg

/* hdl/itc_timers.sv */
// Interval timers, time-of-day counter, serial port and interrupt control
`timescale 1ns/1ps
// Behaviour
// [RULE1] Two timers: 16-bit down-counter, separate latch; writes to latch, reads counter
// [RULE2] Start bit starts or stops each timer at any time
// [RULE3] Port-output enable drives timer output onto port B bit six or seven
// [RULE4] Underflow toggles or pulses output one cycle; toggle high on start
// [RULE5] One-shot: count to zero, interrupt, reload, stop
// [RULE6] Continuous: count to zero, interrupt, reload, repeat
// [RULE7] One-shot high-byte write loads counter and starts counting
// [RULE8] Force-load strobe copies latch into counter at once
// [RULE9] Timer A: clock or pin; timer B: four selectable sources
// [RULE10] Reload on underflow, force load, stopped high write; running write latch only
// [RULE11] 24-bit time-of-day counter increments on rising input edge
// [RULE12] Alarm shares addresses, select bit steers writes; match raises alarm
// [RULE13] Time write halts counter until lowest byte written
// [RULE14] Top-byte read freezes readout until bottom-byte read; counting continues
// [RULE15] Serial input: shift data on rising pin edges, eight then interrupt
// [RULE16] Serial output rate is half timer A underflow rate
// [RULE17] Output driven from timer A clock, MSB first, valid falling to falling
// [RULE18] After eight clocks interrupt; continue if new byte else idle high; code idles only the clock high, data holds the last bit
// [RULE19] Count and data pins are open drain
// [RULE20] Sources set data bits; enabled ones set summary and pull request low
// [RULE21] Reading interrupt data returns it then clears it and releases request
// [RULE22] Mask write: bit 7 picks set or clear, ones in 6-0 act; only bits 4-0 are stored
// [RULE23] Start bit clears itself on one-shot underflow
// [RULE24] Force-load bit reads zero and writing zero does nothing
// [RULE25] Timer A bit selects serial direction: transmit with clock or receive
// [RULE26] Reset clears time, alarm, shift register, mask; timers stopped
module itc_timers
	import itc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CHIP_SELECT_N,
	input wire logic READ_NOT_WRITE,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] WRITE_DATA,
	output logic [7:0] READ_DATA,
	input wire logic COUNT_PIN_IN,
	output logic COUNT_PIN_OUT,
	output logic COUNT_PIN_OE_N,
	input wire logic SERIAL_DATA_PIN_IN,
	output logic SERIAL_DATA_PIN_OUT,
	output logic SERIAL_DATA_PIN_OE_N,
	input wire logic TIME_OF_DAY_PIN,
	input wire logic FLAG_EVENT,
	output logic PORT_B_BIT_SIX,
	output logic PORT_B_BIT_SEVEN,
	output logic PORT_B_SIX_TIMER,
	output logic PORT_B_SEVEN_TIMER,
	output logic [7:0] PORT_B_DIRECTION,
	output logic INTERRUPT_REQ_N
);
	import itc_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic access;
	logic wr;
	logic rd;
	logic [15:0] wr_sel;
	assign access = !CHIP_SELECT_N;
	assign wr = access && !READ_NOT_WRITE;
	assign rd = access && READ_NOT_WRITE;
	// Pin synchronisers: first stage is only read by the second
	logic [2:0] cnt_s;
	logic [1:0] sp_s;
	logic [2:0] tod_s;
	logic [1:0] flag_s;
	logic cnt_rise;
	logic tod_rise;
	logic flag_prev;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cnt_s <= 3'h7;
			sp_s <= 2'h3;
			tod_s <= 3'h7;
			flag_s <= 2'h3;
			flag_prev <= 1'b1;
		end
		else
		begin
			cnt_s <= {cnt_s[1:0], COUNT_PIN_IN};
			sp_s <= {sp_s[0], SERIAL_DATA_PIN_IN};
			tod_s <= {tod_s[1:0], TIME_OF_DAY_PIN};
			flag_s <= {flag_s[0], FLAG_EVENT};
			flag_prev <= flag_s[1];
		end
	end
	assign cnt_rise = cnt_s[1] && !cnt_s[2];
	assign tod_rise = tod_s[1] && !tod_s[2]; // RULE11
	////////////////////////////////////////////////////////////////////////
	// Timers
	logic [7:0] ctrl [2];
	logic [15:0] latch [2];
	logic [15:0] counter [2];
	logic [1:0] tick;
	logic [1:0] under;
	logic [1:0] toggle;
	logic [1:0] pulse;
	logic [1:0] hi_wr;
	logic [1:0] lo_wr;
	logic [1:0] cr_wr;
	itc_tb_source_t tb_src;
	assign tb_src = itc_tb_source_t'(ctrl[1][CRB_SOURCE_LO+1:CRB_SOURCE_LO]);
	assign tick[0] = ctrl[0][CRA_SOURCE] ? cnt_rise : 1'b1; // RULE9
	assign tick[1] = (tb_src == TB_SRC_CLOCK) ? 1'b1 : // RULE9
		(tb_src == TB_SRC_PIN) ? cnt_rise :
		(tb_src == TB_SRC_UNDERFLOW) ? under[0] : (under[0] && cnt_s[1]);
	assign lo_wr[0] = wr && REG_ADDR == REG_TIMER_A_LOW_BYTE;
	assign lo_wr[1] = wr && REG_ADDR == REG_TIMER_B_LOW_BYTE;
	assign hi_wr[0] = wr && REG_ADDR == REG_TIMER_A_HIGH_BYTE;
	assign hi_wr[1] = wr && REG_ADDR == REG_TIMER_B_HIGH_BYTE;
	assign cr_wr[0] = wr && REG_ADDR == REG_CONTROL_A;
	assign cr_wr[1] = wr && REG_ADDR == REG_CONTROL_B;
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_tmr
			logic run;
			logic start_now;
			logic reload;
			logic [7:0] next_ctrl;
			assign run = ctrl[g][CR_START];
			assign under[g] = run && tick[g] && counter[g] == 16'h0000;
			// One-shot high write starts regardless of start bit
			assign start_now = hi_wr[g] && ctrl[g][CR_ONE_SHOT]; // RULE7
			assign reload = under[g] || (cr_wr[g] && WRITE_DATA[CR_LOAD]) ||
				(hi_wr[g] && (!run || start_now)); // RULE8 RULE10
			always_comb
			begin
				next_ctrl = ctrl[g];
				if (under[g] && ctrl[g][CR_ONE_SHOT])
					next_ctrl[CR_START] = 1'b0; // RULE5 RULE23
				if (start_now)
					next_ctrl[CR_START] = 1'b1; // RULE7
				if (cr_wr[g])
				begin
					next_ctrl = WRITE_DATA; // RULE2
					next_ctrl[CR_LOAD] = 1'b0; // RULE24
				end
			end
			always_ff @(posedge SYS_CLK or negedge RST_N)
			begin
				if (!RST_N)
				begin
					ctrl[g] <= CTRL_RESET; // RULE26
					latch[g] <= LATCH_RESET;
					counter[g] <= LATCH_RESET;
					toggle[g] <= 1'b0; // RULE4
					pulse[g] <= 1'b0;
				end
				else
				begin
					ctrl[g] <= next_ctrl;
					if (lo_wr[g])
						latch[g][7:0] <= WRITE_DATA; // RULE1
					if (hi_wr[g])
						latch[g][15:8] <= WRITE_DATA; // RULE1
					if (reload)
						counter[g] <= hi_wr[g] ? {WRITE_DATA, latch[g][7:0]} :
							latch[g]; // RULE5 RULE6 RULE10
					else if (run && tick[g])
						counter[g] <= counter[g] - 16'h0001;
					pulse[g] <= under[g]; // RULE4
					if (next_ctrl[CR_START] && !run)
						toggle[g] <= 1'b1; // RULE4
					else if (under[g])
						toggle[g] <= !toggle[g];
				end
			end
		end
	endgenerate
	logic [1:0] tmr_out;
	assign tmr_out[0] = ctrl[0][CR_TOGGLE] ? toggle[0] : pulse[0]; // RULE4
	assign tmr_out[1] = ctrl[1][CR_TOGGLE] ? toggle[1] : pulse[1];
	assign PORT_B_BIT_SIX = tmr_out[0]; // RULE3
	assign PORT_B_BIT_SEVEN = tmr_out[1];
	assign PORT_B_SIX_TIMER = ctrl[0][CR_PORT_OUT]; // RULE3
	assign PORT_B_SEVEN_TIMER = ctrl[1][CR_PORT_OUT];
	////////////////////////////////////////////////////////////////////////
	// Port B direction register
	logic [7:0] port_b_direction;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			port_b_direction <= BYTE_RESET;
		else if (wr && REG_ADDR == REG_PORT_B_DIRECTION)
			port_b_direction <= WRITE_DATA;
	end
	assign PORT_B_DIRECTION = port_b_direction;
	////////////////////////////////////////////////////////////////////////
	// Time of day
	logic [23:0] time_of_day_counter;
	logic [23:0] alarm;
	logic [23:0] tod_hold;
	logic tod_halt;
	logic tod_frozen;
	logic [2:0] tod_wr;
	logic alarm_hit;
	logic alarm_prev;
	logic alarm_sel;
	assign alarm_sel = ctrl[1][CRB_ALARM_SEL];
	assign tod_wr[0] = wr && REG_ADDR == REG_EVENT_COUNT_LOW;
	assign tod_wr[1] = wr && REG_ADDR == REG_EVENT_COUNT_MID;
	assign tod_wr[2] = wr && REG_ADDR == REG_EVENT_COUNT_HIGH;
	assign alarm_hit = (time_of_day_counter == alarm); // RULE12
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			time_of_day_counter <= TOD_RESET; // RULE26
			alarm <= TOD_RESET;
			tod_hold <= TOD_RESET;
			tod_halt <= 1'b0;
			tod_frozen <= 1'b0;
			alarm_prev <= 1'b1;
		end
		else
		begin
			alarm_prev <= alarm_hit;
			for (int i = 0; i < 3; i++)
			begin
				if (tod_wr[i] && alarm_sel)
					alarm[i*8 +: 8] <= WRITE_DATA; // RULE12
				else if (tod_wr[i])
					time_of_day_counter[i*8 +: 8] <= WRITE_DATA;
			end
			// Lowest byte written last restarts counting
			if (tod_wr[0] && !alarm_sel)
				tod_halt <= 1'b0; // RULE13
			else if ((tod_wr[1] || tod_wr[2]) && !alarm_sel)
				tod_halt <= 1'b1; // RULE13
			if (tod_rise && !tod_halt && tod_wr == 3'h0)
				time_of_day_counter <= time_of_day_counter + 24'h000001; // RULE11
			if (rd && REG_ADDR == REG_EVENT_COUNT_HIGH && !tod_frozen)
			begin
				tod_frozen <= 1'b1; // RULE14
				tod_hold <= time_of_day_counter;
			end
			else if (rd && REG_ADDR == REG_EVENT_COUNT_LOW)
				tod_frozen <= 1'b0; // RULE14
		end
	end
	logic [23:0] tod_view;
	assign tod_view = tod_frozen ? tod_hold : time_of_day_counter; // RULE14
	////////////////////////////////////////////////////////////////////////
	// Serial port
	logic [7:0] serial_shift_data;
	logic [7:0] shifter;
	logic [3:0] bits;
	logic sdr_full;
	logic tx_active;
	logic sclk;
	logic sp_out;
	logic ser_done;
	logic tx_mode;
	logic sdr_wr;
	logic fifo_valid;
	logic fifo_ready;
	logic fifo_in_ready;
	logic [7:0] fifo_data;
	logic [7:0] rx_byte;
	assign tx_mode = ctrl[0][CRA_SERIAL_DIR]; // RULE25
	assign sdr_wr = wr && REG_ADDR == REG_SERIAL_SHIFT_DATA;
	// Eighth bit must join the byte in the very cycle it is pushed
	assign rx_byte = {shifter[6:0], sp_s[1]}; // RULE15
	// Received bytes queue here, sixteen deep; pin edges are ignored while it is full
	itc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.in_valid(ser_done && !tx_mode),
		.in_ready(fifo_in_ready),
		.in_data(rx_byte),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);
	assign fifo_ready = rd && REG_ADDR == REG_SERIAL_SHIFT_DATA;
	logic shift_now;
	// Each underflow half-period of clock, shift on falling edge
	assign shift_now = tx_mode ? (tx_active && under[0] && sclk) // RULE16
		: (cnt_rise && fifo_in_ready); // RULE15
	assign ser_done = shift_now && bits == BITS_PER_BYTE - 4'h1;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			serial_shift_data <= BYTE_RESET;
			shifter <= BYTE_RESET; // RULE26
			bits <= 4'h0;
			sdr_full <= 1'b0;
			tx_active <= 1'b0;
			sclk <= 1'b1;
			sp_out <= 1'b1;
		end
		else
		begin
			if (sdr_wr)
			begin
				serial_shift_data <= WRITE_DATA;
				sdr_full <= 1'b1;
			end
			if (!tx_mode)
			begin
				tx_active <= 1'b0;
				sclk <= 1'b1;
				if (shift_now)
				begin
					shifter <= rx_byte; // RULE15
					bits <= ser_done ? 4'h0 : bits + 4'h1;
				end
			end
			else if (!tx_active)
			begin
				if (sdr_full && under[0])
				begin
					shifter <= serial_shift_data;
					sdr_full <= sdr_wr;
					tx_active <= 1'b1;
					bits <= 4'h0;
				end
			end
			else if (under[0])
			begin
				sclk <= !sclk; // RULE16 RULE17
				if (sclk)
					sp_out <= shifter[7]; // RULE17
				else
				begin
					shifter <= {shifter[6:0], 1'b0};
					if (bits == BITS_PER_BYTE - 4'h1)
					begin
						bits <= 4'h0;
						if (sdr_full && !sdr_wr)
						begin
							shifter <= serial_shift_data; // RULE18
							sdr_full <= 1'b0;
						end
						else
							tx_active <= 1'b0; // RULE18
					end
					else
						bits <= bits + 4'h1;
				end
			end
		end
	end
	logic tx_byte_done;
	assign tx_byte_done = tx_mode && tx_active && under[0] && !sclk &&
		bits == BITS_PER_BYTE - 4'h1;
	// Open drain: drive only a low level
	assign COUNT_PIN_OUT = 1'b0;
	assign COUNT_PIN_OE_N = !(tx_mode && !sclk); // RULE19
	assign SERIAL_DATA_PIN_OUT = 1'b0;
	assign SERIAL_DATA_PIN_OE_N = !(tx_mode && !sp_out); // RULE19
	////////////////////////////////////////////////////////////////////////
	// Interrupt control
	logic [4:0] icr_data;
	logic [4:0] icr_mask;
	logic [4:0] events;
	logic icr_rd;
	logic icr_wr;
	logic summary;
	assign events[IRQ_TA] = under[0];
	assign events[IRQ_TB] = under[1];
	assign events[IRQ_ALARM] = alarm_hit && !alarm_prev; // RULE12
	assign events[IRQ_SERIAL] = (ser_done && !tx_mode) || tx_byte_done;
	assign events[IRQ_FLAG] = !flag_s[1] && flag_prev;
	assign icr_rd = rd && REG_ADDR == REG_INTERRUPT_CONTROL;
	assign icr_wr = wr && REG_ADDR == REG_INTERRUPT_CONTROL;
	assign summary = |(icr_data & icr_mask); // RULE20
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			icr_data <= 5'h00;
			icr_mask <= 5'h00; // RULE26
		end
		else
		begin
			// A new event wins over the read clear
			icr_data <= (icr_rd ? 5'h00 : icr_data) | events; // RULE20 RULE21
			if (icr_wr && WRITE_DATA[IRQ_SET_CLEAR])
				icr_mask <= icr_mask | WRITE_DATA[4:0]; // RULE22
			else if (icr_wr)
				icr_mask <= icr_mask & ~WRITE_DATA[4:0]; // RULE22
		end
	end
	assign INTERRUPT_REQ_N = !summary; // RULE20 RULE21
	////////////////////////////////////////////////////////////////////////
	// Read mux
	logic [7:0] rd_mux;
	assign rd_mux =
		(REG_ADDR == REG_PORT_B_DIRECTION) ? port_b_direction :
		(REG_ADDR == REG_TIMER_A_LOW_BYTE) ? counter[0][7:0] : // RULE1
		(REG_ADDR == REG_TIMER_A_HIGH_BYTE) ? counter[0][15:8] :
		(REG_ADDR == REG_TIMER_B_LOW_BYTE) ? counter[1][7:0] :
		(REG_ADDR == REG_TIMER_B_HIGH_BYTE) ? counter[1][15:8] :
		(REG_ADDR == REG_EVENT_COUNT_LOW) ? tod_view[7:0] :
		(REG_ADDR == REG_EVENT_COUNT_MID) ? tod_view[15:8] :
		(REG_ADDR == REG_EVENT_COUNT_HIGH) ? tod_view[23:16] :
		(REG_ADDR == REG_SERIAL_SHIFT_DATA) ? (tx_mode ? serial_shift_data : fifo_data) :
		(REG_ADDR == REG_INTERRUPT_CONTROL) ? {summary, 2'b00, icr_data} :
		(REG_ADDR == REG_CONTROL_A) ? ctrl[0] :
		(REG_ADDR == REG_CONTROL_B) ? ctrl[1] : 8'h00;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			READ_DATA <= BYTE_RESET;
		else if (rd)
			READ_DATA <= rd_mux;
	end
	////////////////////////////////////////////////////////////////////////
	// Checks
	a_oneshot_stops: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		under[0] && ctrl[0][CR_ONE_SHOT] && !cr_wr[0] && !hi_wr[0]
		|=> !ctrl[0][CR_START])
		else $error("one-shot timer A kept running"); // RULE23
	a_reload_latch: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		under[1] && !hi_wr[1] |=> counter[1] == $past(latch[1]))
		else $error("timer B not reloaded on underflow"); // RULE10
	a_load_reads_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!ctrl[0][CR_LOAD] && !ctrl[1][CR_LOAD])
		else $error("load bit stored"); // RULE24
	a_irq_summary: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(|(events & icr_mask)) && !icr_wr |=> !INTERRUPT_REQ_N)
		else $error("enabled event did not raise request"); // RULE20
	a_read_clears: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		icr_rd |=> icr_data == $past(events))
		else $error("interrupt data not cleared by read"); // RULE21
	a_count_down: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		ctrl[0][CR_START] && tick[0] && counter[0] != 16'h0000 && !cr_wr[0]
		&& !hi_wr[0] |=> counter[0] == $past(counter[0]) - 16'h0001)
		else $error("timer A missed a decrement"); // RULE2
	a_tod_halted: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tod_halt && !(|tod_wr) |=> time_of_day_counter == $past(time_of_day_counter))
		else $error("time counted while halted"); // RULE13
	a_pulse_width: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		pulse[0] && !under[0] |=> !pulse[0])
		else $error("pulse longer than one cycle"); // RULE4
	c_oneshot: cover property (@(posedge SYS_CLK) under[0] && ctrl[0][CR_ONE_SHOT]);
	c_tx_byte: cover property (@(posedge SYS_CLK) tx_byte_done);
	c_rx_byte: cover property (@(posedge SYS_CLK) ser_done && !tx_mode);
	c_alarm: cover property (@(posedge SYS_CLK) events[IRQ_ALARM]);
endmodule : itc_timers

/* verif/itc_peer.sv */
// Serial peer model sharing the open-drain clock and data lines
`timescale 1ns/1ps
module itc_peer
(
	input wire logic cnt_line,
	input wire logic sp_line,
	output logic cnt_rel,
	output logic sp_rel
);
	logic [7:0] rx;
	int rx_bits;
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		cnt_rel = 1'b1;
		sp_rel = 1'b1;
		rx = 8'h00;
		rx_bits = 0;
	end
	////////////////////////////////////////////////////////////////////////
	// Clock stands high between frames; a released line floats to the
	// pull-up level, so no stale bit can pass for data
	task send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			cnt_rel = 1'b0;
			sp_rel = b[i];
			#40;
			cnt_rel = 1'b1;
			#40;
		end
		sp_rel = 1'b1;
	endtask : send
	////////////////////////////////////////////////////////////////////////
	// Sampling on the rising edge lands mid-way in the bit window
	always @(posedge cnt_line)
	begin
		rx <= {rx[6:0], sp_line};
		rx_bits <= rx_bits + 1;
	end
endmodule : itc_peer

/* verif/testbench.sv */
// Self-checking bench for timers, time of day, serial port and interrupts
`timescale 1ns/1ps
module testbench;
	import itc_pkg::*;
	logic clk, rst_n, cs_n, rnw, time_of_day_counter, flag, pw;
	logic [3:0] addr;
	logic [7:0] wdata, rd, b;
	wire logic [7:0] rdata, ddr;
	wire logic cnt_out, cnt_oe_n, sp_out, sp_oe_n, irq_n;
	wire logic pb6, pb7, pb6_t, pb7_t, cnt_rel, sp_rel;
	// Pull-ups: a line is high unless some party pulls it low
	wire logic cnt_line = (cnt_oe_n | cnt_out) & cnt_rel;
	wire logic sp_line = (sp_oe_n | sp_out) & sp_rel;
	int err_count, num_checks, seed, i, n, m;
	logic [7:0] q[$];
	////////////////////////////////////////////////////////////////////////
	itc_timers uut (.SYS_CLK(clk), .RST_N(rst_n), .CHIP_SELECT_N(cs_n),
		.READ_NOT_WRITE(rnw), .REG_ADDR(addr), .WRITE_DATA(wdata),
		.READ_DATA(rdata), .COUNT_PIN_IN(cnt_line), .COUNT_PIN_OUT(cnt_out),
		.COUNT_PIN_OE_N(cnt_oe_n), .SERIAL_DATA_PIN_IN(sp_line),
		.SERIAL_DATA_PIN_OUT(sp_out), .SERIAL_DATA_PIN_OE_N(sp_oe_n),
		.TIME_OF_DAY_PIN(time_of_day_counter), .FLAG_EVENT(flag), .PORT_B_BIT_SIX(pb6),
		.PORT_B_BIT_SEVEN(pb7), .PORT_B_SIX_TIMER(pb6_t),
		.PORT_B_SEVEN_TIMER(pb7_t), .PORT_B_DIRECTION(ddr),
		.INTERRUPT_REQ_N(irq_n));
	itc_peer peer (.cnt_line(cnt_line), .sp_line(sp_line),
		.cnt_rel(cnt_rel), .sp_rel(sp_rel));
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] icr_exp(input logic [4:0] s, m);
		return {|(s & m), 2'b00, s};
	endfunction : icr_exp
	task chk8(input string nm, input logic [7:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk8
	task chk1(input string nm, input logic e, g);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask : chk1
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	// Chip select low for exactly one edge: reads have side effects
	task acc(input logic r, input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		rnw = r;
		addr = a;
		wdata = d;
		@(negedge clk);
		cs_n = 1'b1;
		rd = rdata;
	endtask : acc
	task wr(input logic [3:0] a, input logic [7:0] d);
		acc(1'b0, a, d);
	endtask : wr
	task rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
		acc(1'b1, a, 8'h00);
		chk8(nm, e, rd);
	endtask : rdc
	task todp(input int k);
		repeat (k)
		begin
			time_of_day_counter = 1'b1;
			cyc(4);
			time_of_day_counter = 1'b0;
			cyc(4);
		end
	endtask : todp
	task oneshot;
		wr(REG_TIMER_A_HIGH_BYTE, 8'h00);
		cyc(20);
	endtask : oneshot
	task results;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		err_count++;
		results();
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 67044;
		err_count = 0;
		num_checks = 0;
		{cs_n, rnw, addr, wdata, time_of_day_counter, flag, rst_n} = {2'b11, 12'h000, 3'b010};
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		cyc(3);
		chk1("irq_n", 1'b1, irq_n);
		rdc("ta_lo", REG_TIMER_A_LOW_BYTE, 8'hff);
		rdc("unmapped", 4'hb, 8'h00);
		rdc("icr", REG_INTERRUPT_CONTROL, 8'h00);
		wr(REG_CONTROL_A, 8'h01);
		wr(REG_TIMER_A_LOW_BYTE, 8'h34);
		wr(REG_TIMER_A_HIGH_BYTE, 8'h12);
		rdc("ta_hi", REG_TIMER_A_HIGH_BYTE, 8'hff);
		wr(REG_CONTROL_A, 8'h10);
		rdc("cra", REG_CONTROL_A, 8'h00);
		rdc("ta_lo", REG_TIMER_A_LOW_BYTE, 8'h34);
		rdc("ta_hi", REG_TIMER_A_HIGH_BYTE, 8'h12);
		for (i = 0; i < 5; i++)
		begin
			n = (i == 0) ? 0 : $random(seed);
			wr(REG_TIMER_B_LOW_BYTE, n[7:0]);
			wr(REG_TIMER_B_HIGH_BYTE, n[15:8]);
			rdc("tb_lo", REG_TIMER_B_LOW_BYTE, n[7:0]);
			rdc("tb_hi", REG_TIMER_B_HIGH_BYTE, n[15:8]);
		end
		wr(REG_TIMER_A_LOW_BYTE, 8'h05);
		wr(REG_TIMER_A_HIGH_BYTE, 8'h00);
		wr(REG_CONTROL_A, 8'h08);
		wr(REG_INTERRUPT_CONTROL, 8'h81);
		oneshot();
		chk1("irq_n", 1'b0, irq_n);
		rdc("cra", REG_CONTROL_A, 8'h08);
		rdc("ta_lo", REG_TIMER_A_LOW_BYTE, 8'h05);
		rdc("icr", REG_INTERRUPT_CONTROL, icr_exp(5'h01, 5'h01));
		chk1("irq_n", 1'b1, irq_n);
		rdc("icr", REG_INTERRUPT_CONTROL, 8'h00);
		wr(REG_INTERRUPT_CONTROL, 8'h7e);
		oneshot();
		chk1("irq_n", 1'b0, irq_n);
		wr(REG_INTERRUPT_CONTROL, 8'h01);
		chk1("irq_n", 1'b1, irq_n);
		rdc("icr", REG_INTERRUPT_CONTROL, icr_exp(5'h01, 5'h00));
		wr(REG_TIMER_B_LOW_BYTE, 8'h04);
		wr(REG_TIMER_B_HIGH_BYTE, 8'h00);
		wr(REG_CONTROL_B, 8'h03);
		{n, m, pw} = '0;
		for (i = 0; i < 60; i++)
		begin
			cyc(1);
			n += (pb7 === 1'b1);
			m += (pb7 === 1'b1 && pw !== 1'b1);
			pw = pb7;
		end
		chk1("pb7_pulse", 1'b1, n == m && m > 1);
		chk1("pb7_own", 1'b1, pb7_t);
		wr(REG_CONTROL_B, 8'h06);
		wr(REG_CONTROL_B, 8'h07);
		chk1("pb7_start", 1'b1, pb7);
		wr(REG_CONTROL_B, 8'h00);
		rdc("icr", REG_INTERRUPT_CONTROL, icr_exp(5'h02, 5'h00));
		wr(REG_TIMER_B_LOW_BYTE, 8'h00);
		wr(REG_TIMER_B_HIGH_BYTE, 8'h01);
		wr(REG_CONTROL_B, 8'h21);
		peer.send(8'hff);
		q.push_back(8'hff);
		cyc(4);
		rdc("tb_lo", REG_TIMER_B_LOW_BYTE, 8'hf8);
		wr(REG_CONTROL_B, 8'h00);
		for (i = 0; i < 16; i++)
		begin
			n = $random(seed);
			q.push_back(n[7:0]);
			peer.send(n[7:0]);
		end
		cyc(4);
		rdc("icr", REG_INTERRUPT_CONTROL, icr_exp(5'h08, 5'h00));
		for (i = 0; i < 16; i++)
			rdc("rx", REG_SERIAL_SHIFT_DATA, q[i]);
		wr(REG_TIMER_A_LOW_BYTE, 8'h03);
		wr(REG_TIMER_A_HIGH_BYTE, 8'h00);
		wr(REG_CONTROL_A, 8'h41);
		n = peer.rx_bits;
		b = 8'($random(seed));
		wr(REG_SERIAL_SHIFT_DATA, b);
		for (i = 0; i < 400 && peer.rx_bits < n + 8; i++)
			cyc(1);
		chk8("tx", b, peer.rx);
		chk1("tx_rate", 1'b1, i >= 40);
		cyc(30);
		acc(1'b1, REG_INTERRUPT_CONTROL, 8'h00);
		chk1("icr_sp", 1'b1, rd[IRQ_SERIAL]);
		chk1("cnt_idle", 1'b1, cnt_line);
		chk1("sp_hold", b[0], sp_line);
		wr(REG_CONTROL_A, 8'h06);
		wr(REG_CONTROL_A, 8'h07);
		chk1("pb6_start", 1'b1, pb6);
		wr(REG_CONTROL_A, 8'h02);
		chk1("pb6_own", 1'b1, pb6_t);
		wr(REG_PORT_B_DIRECTION, 8'h5a);
		chk8("ddr", 8'h5a, ddr);
		wr(REG_EVENT_COUNT_HIGH, 8'h12);
		todp(1);
		wr(REG_EVENT_COUNT_MID, 8'h34);
		wr(REG_EVENT_COUNT_LOW, 8'h56);
		todp(3);
		rdc("tod_hi", REG_EVENT_COUNT_HIGH, 8'h12);
		todp(2);
		rdc("tod_mid", REG_EVENT_COUNT_MID, 8'h34);
		rdc("tod_lo", REG_EVENT_COUNT_LOW, 8'h59);
		rdc("tod_lo", REG_EVENT_COUNT_LOW, 8'h5b);
		wr(REG_CONTROL_B, 8'h80);
		wr(REG_EVENT_COUNT_HIGH, 8'h12);
		wr(REG_EVENT_COUNT_MID, 8'h34);
		wr(REG_EVENT_COUNT_LOW, 8'h5d);
		wr(REG_CONTROL_B, 8'h00);
		rdc("tod_lo", REG_EVENT_COUNT_LOW, 8'h5b);
		wr(REG_INTERRUPT_CONTROL, 8'h84);
		acc(1'b1, REG_INTERRUPT_CONTROL, 8'h00);
		todp(2);
		chk1("irq_n", 1'b0, irq_n);
		rdc("icr", REG_INTERRUPT_CONTROL, icr_exp(5'h04, 5'h04));
		wr(REG_INTERRUPT_CONTROL, 8'h04);
		flag = 1'b0;
		cyc(4);
		rdc("icr", REG_INTERRUPT_CONTROL, icr_exp(5'h10, 5'h00));
		// Second reset in mid-run with timers and time counter configured
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		cyc(3);
		chk1("pb6_own", 1'b0, pb6_t);
		rdc("cra", REG_CONTROL_A, 8'h00);
		rdc("tod_lo", REG_EVENT_COUNT_LOW, 8'h00);
		results();
	end
endmodule : testbench
